/* File: shared/mhc_pkg.sv */
// Constants and types shared by the holding-register commit block
package mhc_pkg;

    // Holding-register numbers
    localparam logic [15:0] COMMIT_ADDR = 16'h0900;
    localparam logic [15:0] ONESHOT_ADDR = 16'h0902;
    localparam logic [15:0] ORDER_ADDR = 16'h0400;
    localparam logic [15:0] WORK_BASE = 16'h1000;
    localparam logic [15:0] TRIP_FIRST = 16'h0012;
    localparam logic [15:0] TRIP_LAST = 16'h004e;

    // Working store geometry
    localparam int WORK_WORDS = 16;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;
    localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;

    // Command values
    localparam logic [15:0] CMD_RECALC = 16'h0000;
    localparam logic [15:0] CMD_STORE = 16'h0001;
    localparam logic [15:0] ONESHOT_ARM = 16'h0001;

    // Byte order codes
    localparam logic [1:0] ORDER_BIG = 2'h0;
    localparam logic [1:0] ORDER_LITTLE = 2'h1;
    localparam logic [1:0] ORDER_SPECIAL = 2'h2;
    localparam logic [1:0] ORDER_RESET = 2'h0;
    localparam logic [15:0] ORDER_MAX = 16'h0002;

    // Exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_RANGE = 8'h21;
    localparam logic [7:0] EXC_BUSY = 8'h26;

    // Storage sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SCAN = 4'b0010,
        ST_REQ = 4'b0100,
        ST_REL = 4'b1000
    } mhc_state_e;

endpackage

/* File: hdl/mhc_byte_order.sv */
// Byte order permutation of a frame data field, same in both directions
`timescale 1ns/1ps
`default_nettype none

module mhc_byte_order (
    // Setting
    input wire logic [1:0] order,
    input wire logic two,
    // Data
    input wire logic [31:0] din,
    output logic [31:0] dout
);
    import mhc_pkg::*;

    wire [31:0] one_swap = {16'h0000, din[7:0], din[15:8]};
    wire [31:0] one_keep = {16'h0000, din[15:0]};
    wire [31:0] two_rev = {din[7:0], din[15:8], din[23:16], din[31:24]};
    wire [31:0] two_word = {din[15:0], din[31:16]};
    wire is_little = (order == ORDER_LITTLE);
    wire is_special = (order == ORDER_SPECIAL);
    wire [31:0] one_out = is_little ? one_swap : one_keep; // see R11
    wire [31:0] two_out = is_little ? two_rev : (is_special ? two_word : din); // see R12

    assign dout = two ? two_out : one_out;

endmodule // mhc_byte_order

`default_nettype wire

/* File: hdl/mhc_holding_commit.sv */
// Holding-register writes, commit sequencer, busy coil and byte order
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: Writes change working value only, not storage
// R2: Command zero recalculates control variables only
// R3: Command one stores changed values to storage
// R4: Command two or more does both
// R5: Busy coil shows storage write in progress
// R6: Control variables change only on recalculation
// R7: One-shot arms storage for next write only
// R8: Master keeps storage writes rare
// R9: Byte order affects data fields only
// R10: Order codes big, little, special; big default
// R11: Single word: little swaps, others high first
// R12: Two words: big, reversed, or low word first
// R13: Trip history reads always big order
// R14: Writes while storing rejected with code 26h
// R15: Coil rises at start, falls after completion
module mhc_holding_commit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Decoded holding-register request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_two,
    input wire logic [15:0] req_addr,
    input wire logic [31:0] req_bytes,
    // Answer
    output logic rsp_valid,
    output logic [7:0] rsp_exc,
    output logic [31:0] rsp_bytes,
    // Trip history monitor
    input wire logic [31:0] trip_rd_data,
    // Control variables
    output logic [mhc_pkg::WORK_WORDS*16-1:0] ctrl_vars_q,
    output logic recalc_pulse,
    // Non-volatile store
    output logic nv_req,
    output logic [mhc_pkg::IDX_W-1:0] nv_addr,
    output logic [15:0] nv_data,
    input wire logic nv_ack,
    // Write-in-progress coil
    output logic busy_coil
);
    import mhc_pkg::*;

    function automatic logic is_work(input logic [15:0] a);
        return (a >= WORK_BASE) && (a < WORK_BASE + 16'(WORK_WORDS));
    endfunction

    function automatic logic is_trip(input logic [15:0] a);
        return (a >= TRIP_FIRST) && (a <= TRIP_LAST);
    endfunction

    mhc_state_e st_q;
    logic [15:0] mem_q [WORK_WORDS];
    logic [15:0] ctrl_q [WORK_WORDS];
    logic [WORK_WORDS-1:0] dirty_q;
    logic [WORK_WORDS-1:0] pend_q;
    logic [IDX_W-1:0] scan_q;
    logic [1:0] order_q;
    logic os_armed_q;
    logic ack_m_q;
    logic ack_s_q;
    logic recalc_q;
    logic rsp_valid_q;
    logic [7:0] rsp_exc_q;
    logic [31:0] rsp_bytes_q;
    logic nv_req_q;
    logic [IDX_W-1:0] nv_addr_q;
    logic [15:0] nv_data_q;
    logic [31:0] wval;
    logic [31:0] rbytes;
    logic [WORK_WORDS-1:0] set_w;
    logic [WORK_WORDS-1:0] clr_w;

    // Address decode
    wire [15:0] addr_nx = req_addr + 16'h0001;
    wire [IDX_W-1:0] idx = IDX_W'(req_addr - WORK_BASE);
    wire [IDX_W-1:0] idx_lo = idx + IDX_ONE;
    wire hit_work = is_work(req_addr) && (!req_two || is_work(addr_nx));
    wire hit_trip = is_trip(req_addr) && (!req_two || is_trip(addr_nx));
    wire hit_commit = !req_two && (req_addr == COMMIT_ADDR);
    wire hit_os = !req_two && (req_addr == ONESHOT_ADDR);
    wire hit_order = !req_two && (req_addr == ORDER_ADDR);
    wire busy = (st_q != ST_IDLE);

    // Write qualification
    wire wr_req = req_valid && req_write;
    wire wr_ok = wr_req && !busy; // see R14
    wire rd_ok = req_valid && !req_write;
    wire work_wr = wr_ok && hit_work; // see R1
    wire cmd_wr = wr_ok && hit_commit;
    wire os_wr = wr_ok && hit_os && (wval[15:0] == ONESHOT_ARM);
    wire ord_bad = wr_ok && hit_order && (wval[15:0] > ORDER_MAX);
    wire ord_wr = wr_ok && hit_order && !ord_bad; // see R10
    wire wr_map = hit_work || hit_commit || hit_os || hit_order;
    wire recalc = cmd_wr && (wval[15:0] != CMD_STORE); // see R2 R4
    wire store = cmd_wr && (wval[15:0] != CMD_RECALC); // see R3 R4
    wire os_fire = work_wr && os_armed_q; // see R7

    // Read data and order selection
    wire [31:0] work_rd = req_two ? {mem_q[idx], mem_q[idx_lo]} : {16'h0000, mem_q[idx]};
    wire [31:0] trip_rd = req_two ? trip_rd_data : {16'h0000, trip_rd_data[15:0]};
    wire [31:0] order_rd = {30'h00000000, order_q};
    wire [31:0] rval = hit_trip ? trip_rd : (hit_work ? work_rd : order_rd);
    wire rd_map = hit_work || hit_trip || hit_order;
    wire [1:0] rd_order = hit_trip ? ORDER_BIG : order_q; // see R13

    // Incoming data field to value
    mhc_byte_order u_wr_order (
        .order(order_q),
        .two(req_two),
        .din(req_bytes),
        .dout(wval)
    ); // see R9

    // Outgoing value to data field
    mhc_byte_order u_rd_order (
        .order(rd_order),
        .two(req_two),
        .din(rval),
        .dout(rbytes)
    ); // see R9 R11 R12

    // Answer selection
    wire [7:0] wr_exc = !wr_map ? EXC_ADDR : (ord_bad ? EXC_RANGE : EXC_NONE);
    wire [7:0] exc_d = req_write ? (busy ? EXC_BUSY : wr_exc) : (rd_map ? EXC_NONE : EXC_ADDR);
    wire [31:0] bytes_d = (rd_ok && rd_map) ? rbytes : 32'h00000000;

    // Storage handshake
    wire nv_done = (st_q == ST_REQ) && ack_s_q;
    wire pend_now = pend_q[scan_q];

    // Per-word working store and control variables
    genvar g;
    generate
        for (g = 0; g < WORK_WORDS; g++) begin : g_word
            wire we_hi = work_wr && (idx == IDX_W'(g));
            wire we_lo = work_wr && req_two && (idx_lo == IDX_W'(g));
            wire [15:0] wdat = (req_two && we_hi) ? wval[31:16] : wval[15:0];
            assign set_w[g] = we_hi || we_lo;
            assign clr_w[g] = nv_done && (scan_q == IDX_W'(g));
            assign ctrl_vars_q[g*16 +: 16] = ctrl_q[g];
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[g] <= 16'h0000;
                end else if (set_w[g]) begin
                    mem_q[g] <= wdat; // see R1
                end
            end
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q[g] <= 16'h0000;
                end else if (recalc) begin
                    ctrl_q[g] <= mem_q[g]; // see R6
                end
            end
        end
    endgenerate

    // Acknowledge synchroniser
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
        end else begin
            ack_m_q <= nv_ack;
            ack_s_q <= ack_m_q;
        end
    end

    // Settings, dirty marks and pulses
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            order_q <= ORDER_RESET;
            os_armed_q <= 1'b0;
            dirty_q <= 16'h0000;
            recalc_q <= 1'b0;
        end else begin
            if (ord_wr) begin
                order_q <= wval[1:0]; // see R10
            end
            if (os_wr) begin
                os_armed_q <= 1'b1; // see R7
            end else if (wr_ok) begin
                os_armed_q <= 1'b0; // see R7
            end
            dirty_q <= (dirty_q & ~clr_w) | set_w;
            recalc_q <= recalc; // see R2
        end
    end

    // Storage sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            pend_q <= 16'h0000;
            scan_q <= IDX_ZERO;
            nv_req_q <= 1'b0;
            nv_addr_q <= IDX_ZERO;
            nv_data_q <= 16'h0000;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    scan_q <= IDX_ZERO;
                    if (store) begin
                        pend_q <= dirty_q; // see R3 R15
                        st_q <= ST_SCAN;
                    end else if (os_fire) begin
                        pend_q <= set_w; // see R7 R15
                        st_q <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (pend_q == 16'h0000) begin
                        st_q <= ST_IDLE; // see R15
                    end else if (pend_now) begin
                        nv_addr_q <= scan_q;
                        nv_data_q <= mem_q[scan_q];
                        nv_req_q <= 1'b1;
                        st_q <= ST_REQ;
                    end else begin
                        scan_q <= scan_q + IDX_ONE;
                    end
                end
                ST_REQ: begin
                    if (ack_s_q) begin
                        nv_req_q <= 1'b0;
                        pend_q[scan_q] <= 1'b0;
                        st_q <= ST_REL;
                    end
                end
                ST_REL: begin
                    if (!ack_s_q) begin
                        scan_q <= scan_q + IDX_ONE;
                        st_q <= ST_SCAN;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Answer registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_exc_q <= EXC_NONE;
            rsp_bytes_q <= 32'h00000000;
        end else begin
            rsp_valid_q <= req_valid;
            if (req_valid) begin
                rsp_exc_q <= exc_d; // see R14
                rsp_bytes_q <= bytes_d;
            end
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_exc = rsp_exc_q;
    assign rsp_bytes = rsp_bytes_q;
    assign recalc_pulse = recalc_q;
    assign nv_req = nv_req_q;
    assign nv_addr = nv_addr_q;
    assign nv_data = nv_data_q;
    assign busy_coil = busy; // see R5

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    wire [15:0] trip_lo = trip_rd_data[15:0];
    wire [15:0] wr_word = req_two ? wval[31:16] : wval[15:0];

    a_busy_reject: assert property (wr_req && busy |=> rsp_valid && rsp_exc == EXC_BUSY) // see R14
        else $error("write during storage not rejected");
    a_work_ram: assert property (work_wr && !os_armed_q |=> // see R1
        !busy_coil && mem_q[$past(idx)] == $past(wr_word))
        else $error("working write wrong or started storage");
    a_recalc_only: assert property (cmd_wr && wval[15:0] == CMD_RECALC |=> // see R2
        recalc_pulse && !busy_coil)
        else $error("recalc command misbehaved");
    a_store_only: assert property (cmd_wr && wval[15:0] == CMD_STORE |=> // see R3
        busy_coil && !recalc_pulse)
        else $error("store command misbehaved");
    a_store_both: assert property (cmd_wr && wval[15:0] > CMD_STORE |=> // see R4
        busy_coil && recalc_pulse)
        else $error("combined command misbehaved");
    a_coil_nv: assert property (nv_req |-> busy_coil) // see R5
        else $error("storage request without busy coil");
    a_ctrl_hold: assert property (!recalc_pulse |-> $stable(ctrl_vars_q)) // see R6
        else $error("control variables changed without recalc");
    a_one_shot: assert property (os_fire |=> busy_coil && !os_armed_q ##1 !os_armed_q) // see R7
        else $error("one-shot write not stored or not disarmed");
    a_order_range: assert property (order_q <= ORDER_SPECIAL) // see R10
        else $error("illegal byte order held");
    a_trip_big: assert property (rd_ok && hit_trip && !req_two |=> // see R13
        rsp_bytes == {16'h0000, $past(trip_lo)})
        else $error("trip history not big order");
    a_busy_done: assert property ($fell(busy_coil) |-> // see R15
        $past(pend_q) == 16'h0000 && !nv_req)
        else $error("busy coil fell before storage finished");

    c_store: cover property (store && dirty_q != 16'h0000 ##[1:60] $fell(busy_coil));
    c_one_shot: cover property (os_fire ##[1:30] nv_req);
    c_reject: cover property (wr_req && busy);
    c_little_rd: cover property (rd_ok && hit_work && req_two && order_q == ORDER_LITTLE);

endmodule // mhc_holding_commit

`default_nettype wire

/* File: verification/mhc_nv_model.sv */
// Non-volatile store partner answering the four-phase storage link
`timescale 1ns/1ps
`default_nettype none

module mhc_nv_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Storage link
    input wire logic nv_req,
    input wire logic [mhc_pkg::IDX_W-1:0] nv_addr,
    input wire logic [15:0] nv_data,
    output logic nv_ack,
    // Answer speed in clock cycles
    input wire logic [3:0] ack_delay
);
    import mhc_pkg::*;
    logic [15:0] stored [WORK_WORDS];
    int store_cnt;
    int wait_cnt;

    // Ack stays high until the request drops, then falls at once
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_ack <= 1'b0;
            store_cnt <= 0;
            wait_cnt <= 0;
        end else if (nv_req && !nv_ack) begin
            if (wait_cnt >= int'(ack_delay)) begin
                nv_ack <= 1'b1;
                stored[nv_addr] <= nv_data;
                store_cnt <= store_cnt + 1;
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end else if (!nv_req) begin
            nv_ack <= 1'b0;
        end
    end
endmodule // mhc_nv_model

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking testbench of the holding-register commit block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import mhc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_two = 1'b0;
    logic [15:0] req_addr = 16'h0;
    logic [31:0] req_bytes = 32'h0;
    logic [31:0] trip_rd_data = 32'h0a0b0c0d;
    logic [3:0] ack_delay = 4'h5;
    logic rsp_valid, recalc_pulse, nv_req, nv_ack, busy_coil;
    logic [7:0] rsp_exc;
    logic [31:0] rsp_bytes;
    logic [WORK_WORDS*16-1:0] ctrl_vars;
    logic [IDX_W-1:0] nv_addr;
    logic [15:0] nv_data;
    int num_errors = 0;
    int samples_checked = 0;
    int exp_cnt = 0;
    logic [31:0] f2 [3] = '{32'h01020304, 32'h04030201, 32'h03040102};
    logic [15:0] f1 [3] = '{16'h0102, 16'h0201, 16'h0102};
    logic [15:0] w_ord [3] = '{16'h0000, 16'h0001, 16'h0200};
    logic [15:0] r_ord [3] = '{16'h0000, 16'h0100, 16'h0002};
    logic [15:0] cmds [2] = '{16'h0002, 16'hffff};
    logic [15:0] vals [2] = '{16'hbeef, 16'h2468};

    mhc_holding_commit dut (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_two(req_two), .req_addr(req_addr),
        .req_bytes(req_bytes), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc),
        .rsp_bytes(rsp_bytes), .trip_rd_data(trip_rd_data), .ctrl_vars_q(ctrl_vars),
        .recalc_pulse(recalc_pulse), .nv_req(nv_req), .nv_addr(nv_addr),
        .nv_data(nv_data), .nv_ack(nv_ack), .busy_coil(busy_coil));

    mhc_nv_model store (.ref_clk(ref_clk), .rst_n(rst_n), .nv_req(nv_req),
        .nv_addr(nv_addr), .nv_data(nv_data), .nv_ack(nv_ack), .ack_delay(ack_delay));

    always #50 ref_clk = ~ref_clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One request at a falling edge, answer looked at one cycle later
    task automatic xfer(input logic wr, input logic two, input logic [15:0] addr,
        input logic [31:0] data, input logic [7:0] exc, input logic [31:0] rd);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_two = two;
        req_addr = addr;
        req_bytes = data;
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        chk("rsp_exc", {24'h0, exc}, {24'h0, rsp_exc});
        chk("rsp_bytes", rd, rsp_bytes);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_coil !== 1'b0 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        chk("busy_coil idle", 32'h0, {31'h0, busy_coil});
    endtask

    function automatic logic [31:0] cw(input int g);
        return {16'h0, ctrl_vars[16*g +: 16]};
    endfunction

    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(5000 * 100);
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        xfer(1'b0, 1'b0, ORDER_ADDR, 32'h0, EXC_NONE, 32'h0);
        xfer(1'b1, 1'b0, 16'h1003, 32'h1234, EXC_NONE, 32'h0);
        xfer(1'b0, 1'b0, 16'h1003, 32'h0, EXC_NONE, 32'h1234);
        chk("store_cnt", 32'h0, 32'(store.store_cnt));
        chk("ctrl word 3", 32'h0, cw(3));
        xfer(1'b1, 1'b0, COMMIT_ADDR, 32'h0, EXC_NONE, 32'h0);
        chk("recalc_pulse", 32'h1, {31'h0, recalc_pulse});
        chk("ctrl word 3", 32'h1234, cw(3));
        chk("busy_coil", 32'h0, {31'h0, busy_coil});
        // Few storage commands on purpose to spare the store
        xfer(1'b1, 1'b0, COMMIT_ADDR, 32'h1, EXC_NONE, 32'h0);
        chk("busy_coil", 32'h1, {31'h0, busy_coil});
        xfer(1'b1, 1'b0, 16'h1003, 32'hdead, EXC_BUSY, 32'h0);
        wait_idle();
        exp_cnt = 1;
        chk("store_cnt", 32'(exp_cnt), 32'(store.store_cnt));
        chk("stored 3", 32'h1234, {16'h0, store.stored[3]});
        xfer(1'b0, 1'b0, 16'h1003, 32'h0, EXC_NONE, 32'h1234);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 1'b0, 16'h1005, {16'h0, vals[i]}, EXC_NONE, 32'h0);
            xfer(1'b1, 1'b0, COMMIT_ADDR, {16'h0, cmds[i]}, EXC_NONE, 32'h0);
            chk("recalc_pulse", 32'h1, {31'h0, recalc_pulse});
            chk("busy_coil", 32'h1, {31'h0, busy_coil});
            wait_idle();
            exp_cnt++;
            chk("stored 5", {16'h0, vals[i]}, {16'h0, store.stored[5]});
            chk("ctrl word 5", {16'h0, vals[i]}, cw(5));
        end
        ack_delay = 4'h0;
        xfer(1'b1, 1'b0, ONESHOT_ADDR, 32'h1, EXC_NONE, 32'h0);
        xfer(1'b1, 1'b0, 16'h1007, 32'h5555, EXC_NONE, 32'h0);
        @(negedge ref_clk);
        chk("busy_coil", 32'h1, {31'h0, busy_coil});
        wait_idle();
        exp_cnt++;
        chk("stored 7", 32'h5555, {16'h0, store.stored[7]});
        xfer(1'b1, 1'b0, 16'h1008, 32'h6666, EXC_NONE, 32'h0);
        @(negedge ref_clk);
        chk("busy_coil", 32'h0, {31'h0, busy_coil});
        xfer(1'b1, 1'b0, ONESHOT_ADDR, 32'h2, EXC_NONE, 32'h0);
        xfer(1'b1, 1'b0, 16'h1009, 32'h7777, EXC_NONE, 32'h0);
        @(negedge ref_clk);
        chk("busy_coil", 32'h0, {31'h0, busy_coil});
        chk("store_cnt", 32'(exp_cnt), 32'(store.store_cnt));
        xfer(1'b1, 1'b0, ORDER_ADDR, 32'h3, EXC_RANGE, 32'h0);
        xfer(1'b1, 1'b1, 16'h100a, 32'h01020304, EXC_NONE, 32'h0);
        xfer(1'b1, 1'b0, 16'h100c, 32'h0102, EXC_NONE, 32'h0);
        for (int o = 0; o < 3; o++) begin
            xfer(1'b1, 1'b0, ORDER_ADDR, {16'h0, w_ord[o]}, EXC_NONE, 32'h0);
            xfer(1'b0, 1'b0, ORDER_ADDR, 32'h0, EXC_NONE, {16'h0, r_ord[o]});
            xfer(1'b0, 1'b1, 16'h100a, 32'h0, EXC_NONE, f2[o]);
            xfer(1'b0, 1'b0, 16'h100c, 32'h0, EXC_NONE, {16'h0, f1[o]});
            xfer(1'b0, 1'b1, TRIP_FIRST, 32'h0, EXC_NONE, 32'h0a0b0c0d);
            xfer(1'b0, 1'b0, TRIP_LAST, 32'h0, EXC_NONE, 32'h0c0d);
        end
        xfer(1'b1, 1'b0, ORDER_ADDR, 32'h0001, EXC_NONE, 32'h0);
        xfer(1'b1, 1'b0, 16'h100d, 32'h0201, EXC_NONE, 32'h0);
        xfer(1'b1, 1'b0, ORDER_ADDR, 32'h0000, EXC_NONE, 32'h0);
        xfer(1'b0, 1'b0, 16'h100d, 32'h0, EXC_NONE, 32'h0102);
        xfer(1'b0, 1'b0, 16'h2000, 32'h0, EXC_ADDR, 32'h0);
        xfer(1'b0, 1'b1, 16'h100f, 32'h0, EXC_ADDR, 32'h0);
        xfer(1'b1, 1'b1, COMMIT_ADDR, 32'h1, EXC_ADDR, 32'h0);
        chk("busy_coil", 32'h0, {31'h0, busy_coil});
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
